// File: rtl/movf_params.svh
// Constants for the monitor overflow interrupt block
`ifndef MOVF_PARAMS_SVH
`define MOVF_PARAMS_SVH
`define MOVF_NUM_RIS      4
`define MOVF_RIS_W        2
`define MOVF_NUM_MON      64
`define MOVF_MON_W        16
`define MOVF_IDX_W        6
`define MOVF_NUM_TYPE     2
`define MOVF_TYPE_CSU     0
`define MOVF_TYPE_BANDWIDTH_USAGE    1
`define MOVF_BMP_W        32
`define MOVF_BMP_MASK     16'hFFE0
`define MOVF_SPACE_S      0
`define MOVF_SPACE_NS     1
`define MOVF_NUM_SPACE    2
`define MOVF_NUM_INST     (`MOVF_NUM_SPACE*`MOVF_NUM_TYPE*`MOVF_NUM_RIS*`MOVF_NUM_MON)
`endif

// File: rtl/movf_pkg.sv
// Types shared by the monitor overflow interrupt block
package movf_pkg;
  typedef struct packed {
    logic [31:0] addr_low;
    logic [31:0] addr_high;
    logic [31:0] attributes;
    logic [31:0] payload;
    logic [31:0] partition_info;
  } movf_msg_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
    logic [31:0] attributes;
    logic [31:0] payload;
    logic [31:0] partition_info;
  } movf_msg_wr_t;

  typedef struct packed {
    logic        has_wired_ovf_irq;
    logic        has_msg_ovf_irq;
    logic        has_summary_reg;
  } movf_mon_id_t;
endpackage : movf_pkg

// File: rtl/movf_irq.sv
// Overflow flags, summary, bitmaps and interrupt signalling for monitors
`timescale 1ns/100ps
`include "movf_params.svh"
module movf_irq
  import movf_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // Overflow event per space, type, resource instance, monitor (one-cycle pulses)
  input  wire logic [`MOVF_NUM_INST-1:0]             ovf_event,
  input  wire logic [`MOVF_NUM_INST-1:0]             ovf_event_long,
  // Software write to a control register: clear flags, set enable
  input  wire logic                                  ctl_wr,
  input  wire logic                                  ctl_space,
  input  wire logic                                  ctl_type,
  input  wire logic [`MOVF_RIS_W-1:0]                ctl_ris,
  input  wire logic [`MOVF_IDX_W-1:0]                ctl_mon,
  input  wire logic                                  ctl_ovf_flag,
  input  wire logic                                  ctl_ovf_flag_long,
  input  wire logic                                  ctl_ovf_irq_enable,
  // Monitor select per space
  input  wire logic [`MOVF_RIS_W-1:0]                resource_instance_select_s,
  input  wire logic [`MOVF_MON_W-1:0]                monitor_instance_index_s,
  input  wire logic [`MOVF_RIS_W-1:0]                resource_instance_select_ns,
  input  wire logic [`MOVF_MON_W-1:0]                monitor_instance_index_ns,
  input  wire movf_msg_cfg_t                         msg_cfg_s,
  input  wire movf_msg_cfg_t                         msg_cfg_ns,
  input  wire logic                                  msg_mode,
  output logic                                       ovf_irq_line_s,
  output logic                                       ovf_irq_line_ns,
  output movf_msg_wr_t                               ovf_msg_wr_s,
  output movf_msg_wr_t                               ovf_msg_wr_ns,
  output logic [`MOVF_NUM_RIS+`MOVF_NUM_TYPE-1:0]    overflow_summary_reg_s,
  output logic [`MOVF_NUM_RIS+`MOVF_NUM_TYPE-1:0]    overflow_summary_reg_ns,
  output logic [`MOVF_BMP_W-1:0]                     cache_usage_ovf_bitmap_s,
  output logic [`MOVF_BMP_W-1:0]                     bandwidth_usage_ovf_bitmap_s,
  output logic [`MOVF_BMP_W-1:0]                     cache_usage_ovf_bitmap_ns,
  output logic [`MOVF_BMP_W-1:0]                     bandwidth_usage_ovf_bitmap_ns,
  output movf_mon_id_t                               monitor_id_reg,
  output logic                                       cache_usage_has_ovf_bitmap,
  output logic                                       bandwidth_usage_has_ovf_bitmap
);

  localparam int NINST = `MOVF_NUM_INST;
  localparam int NPER  = `MOVF_NUM_TYPE*`MOVF_NUM_RIS*`MOVF_NUM_MON;

  // Flat instance index: {space, type, ris, mon}
  function automatic int inst_idx(input int sp, input int ty, input int resource_instance_select, input int mon);
    inst_idx = ((sp*`MOVF_NUM_TYPE + ty)*`MOVF_NUM_RIS + resource_instance_select)*`MOVF_NUM_MON + mon;
  endfunction : inst_idx

  // ---------------------------------------------------------------
  // Per-instance control state
  // ---------------------------------------------------------------
  logic [NINST-1:0] ovf_flag_r;
  logic [NINST-1:0] ovf_flag_long_r;
  logic [NINST-1:0] ovf_irq_enable_r;
  logic [NINST-1:0] ovf_flag_nxt;
  logic [NINST-1:0] ovf_flag_long_nxt;
  logic [NINST-1:0] ovf_irq_enable_nxt;
  logic [NINST-1:0] ctl_hit;
  logic [NINST-1:0] rise;

  // The control address packs straight into the flat index that inst_idx builds
  logic [$clog2(NINST)-1:0] ctl_sel;
  assign ctl_sel = {ctl_space, ctl_type, ctl_ris, ctl_mon};

  genvar gi;
  generate
    for (gi = 0; gi < NINST; gi++) begin : g_inst
      assign ctl_hit[gi] = ctl_wr && (int'(ctl_sel) == gi);
      // Set wins over a clear written in the same cycle
      assign ovf_flag_nxt[gi] = ovf_event[gi] |
             (ctl_hit[gi] ? ctl_ovf_flag : ovf_flag_r[gi]);
      assign ovf_flag_long_nxt[gi] = ovf_event_long[gi] |
             (ctl_hit[gi] ? ctl_ovf_flag_long : ovf_flag_long_r[gi]);
      assign ovf_irq_enable_nxt[gi] = ctl_hit[gi] ? ctl_ovf_irq_enable : ovf_irq_enable_r[gi];
      // A software write of 1 sets a flag but never makes an interrupt edge
      // Only a hardware overflow on a clear flag counts as an interrupt edge
      assign rise[gi] = (ovf_event[gi] | ovf_event_long[gi]) &
             ~(ovf_flag_r[gi] | ovf_flag_long_r[gi]) & ovf_irq_enable_nxt[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r       <= '0;
      ovf_flag_long_r  <= '0;
      ovf_irq_enable_r <= '0;
    end else begin
      ovf_flag_r       <= ovf_flag_nxt;
      ovf_flag_long_r  <= ovf_flag_long_nxt;
      ovf_irq_enable_r <= ovf_irq_enable_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Per-space interrupt, summary and bitmaps
  // ---------------------------------------------------------------
  // Outputs are built from next state so they move at the same edge as the flags
  wire [NINST-1:0] any_flag = ovf_flag_nxt | ovf_flag_long_nxt;
  wire [NPER-1:0]  flag_sp [`MOVF_NUM_SPACE];
  wire [NPER-1:0]  en_sp   [`MOVF_NUM_SPACE];
  wire [NPER-1:0]  rise_sp [`MOVF_NUM_SPACE];
  wire [`MOVF_RIS_W-1:0] sel_ris [`MOVF_NUM_SPACE];
  wire [`MOVF_MON_W-1:0] sel_base [`MOVF_NUM_SPACE];
  logic [`MOVF_NUM_RIS+`MOVF_NUM_TYPE-1:0] summ_nxt [`MOVF_NUM_SPACE];
  logic [`MOVF_BMP_W-1:0] bmp_nxt [`MOVF_NUM_SPACE][`MOVF_NUM_TYPE];
  wire level_nxt [`MOVF_NUM_SPACE];
  wire edge_nxt  [`MOVF_NUM_SPACE];

  assign sel_ris[`MOVF_SPACE_S]   = resource_instance_select_s;
  assign sel_ris[`MOVF_SPACE_NS]  = resource_instance_select_ns;
  assign sel_base[`MOVF_SPACE_S]  = monitor_instance_index_s & `MOVF_BMP_MASK;
  assign sel_base[`MOVF_SPACE_NS] = monitor_instance_index_ns & `MOVF_BMP_MASK;

  genvar gs;
  generate
    for (gs = 0; gs < `MOVF_NUM_SPACE; gs++) begin : g_space
      assign flag_sp[gs] = any_flag[gs*NPER +: NPER];
      assign en_sp[gs]   = ovf_irq_enable_nxt[gs*NPER +: NPER];
      assign rise_sp[gs] = rise[gs*NPER +: NPER];
      // Each space sees only its own flags and enables
      assign level_nxt[gs] = |(flag_sp[gs] & en_sp[gs]);
      assign edge_nxt[gs]  = |rise_sp[gs];

      // Type bits follow the resource instance chosen by this space's select
      always_comb begin
        summ_nxt[gs] = '0;
        for (int t = 0; t < `MOVF_NUM_TYPE; t++) begin
          for (int r = 0; r < `MOVF_NUM_RIS; r++) begin
            for (int m = 0; m < `MOVF_NUM_MON; m++) begin
              if (flag_sp[gs][inst_idx(0, t, r, m)]) begin
                summ_nxt[gs][r] = 1'b1;
                if (r == int'(sel_ris[gs]))
                  summ_nxt[gs][`MOVF_NUM_RIS+t] = 1'b1;
              end
            end
          end
        end
      end

      always_comb begin
        for (int t = 0; t < `MOVF_NUM_TYPE; t++) begin
          for (int b = 0; b < `MOVF_BMP_W; b++) begin
            // Instances beyond the implemented count read as zero
            if (int'(sel_base[gs]) + b < `MOVF_NUM_MON)
              bmp_nxt[gs][t][b] = flag_sp[gs][inst_idx(0, t, int'(sel_ris[gs]),
                                  int'(sel_base[gs]) + b)];
            else
              bmp_nxt[gs][t][b] = 1'b0;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_irq_line_s                <= 1'b0;
      ovf_irq_line_ns               <= 1'b0;
      ovf_msg_wr_s                  <= '0;
      ovf_msg_wr_ns                 <= '0;
      overflow_summary_reg_s        <= '0;
      overflow_summary_reg_ns       <= '0;
      cache_usage_ovf_bitmap_s      <= '0;
      bandwidth_usage_ovf_bitmap_s  <= '0;
      cache_usage_ovf_bitmap_ns     <= '0;
      bandwidth_usage_ovf_bitmap_ns <= '0;
      monitor_id_reg                <= '0;
      cache_usage_has_ovf_bitmap    <= 1'b0;
      bandwidth_usage_has_ovf_bitmap <= 1'b0;
    end else begin
      // Message mode trades the level line for a one-cycle edge
      ovf_irq_line_s  <= msg_mode ? 1'b0 : level_nxt[`MOVF_SPACE_S];
      ovf_irq_line_ns <= msg_mode ? 1'b0 : level_nxt[`MOVF_SPACE_NS];
      ovf_msg_wr_s    <= '{valid: msg_mode & edge_nxt[`MOVF_SPACE_S],
                           addr: {msg_cfg_s.addr_high, msg_cfg_s.addr_low},
                           attributes: msg_cfg_s.attributes,
                           payload: msg_cfg_s.payload,
                           partition_info: msg_cfg_s.partition_info};
      ovf_msg_wr_ns   <= '{valid: msg_mode & edge_nxt[`MOVF_SPACE_NS],
                           addr: {msg_cfg_ns.addr_high, msg_cfg_ns.addr_low},
                           attributes: msg_cfg_ns.attributes,
                           payload: msg_cfg_ns.payload,
                           partition_info: msg_cfg_ns.partition_info};
      overflow_summary_reg_s        <= summ_nxt[`MOVF_SPACE_S];
      overflow_summary_reg_ns       <= summ_nxt[`MOVF_SPACE_NS];
      cache_usage_ovf_bitmap_s      <= bmp_nxt[`MOVF_SPACE_S][`MOVF_TYPE_CSU];
      bandwidth_usage_ovf_bitmap_s  <= bmp_nxt[`MOVF_SPACE_S][`MOVF_TYPE_BANDWIDTH_USAGE];
      cache_usage_ovf_bitmap_ns     <= bmp_nxt[`MOVF_SPACE_NS][`MOVF_TYPE_CSU];
      bandwidth_usage_ovf_bitmap_ns <= bmp_nxt[`MOVF_SPACE_NS][`MOVF_TYPE_BANDWIDTH_USAGE];
      // Capability bits are constants that come up one edge after reset
      monitor_id_reg <= '{has_wired_ovf_irq: 1'b1, has_msg_ovf_irq: 1'b1,
                          has_summary_reg: 1'b1};
      cache_usage_has_ovf_bitmap     <= 1'b1;
      bandwidth_usage_has_ovf_bitmap <= 1'b1;
    end
  end

endmodule : movf_irq

// File: bench/movf_irq_sink.sv
// Interrupt controller model that receives the overflow messages
`timescale 1ns/100ps
module movf_irq_sink
  import movf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire movf_msg_wr_t ovf_msg_wr_s,
  input  wire movf_msg_wr_t ovf_msg_wr_ns,
  output logic [7:0]        msg_cnt_s,
  output logic [7:0]        msg_cnt_ns,
  output logic [31:0]       last_payload_ns
);
  // Each valid cycle is one edge event, so count it once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_cnt_s       <= 8'h00;
      msg_cnt_ns      <= 8'h00;
      last_payload_ns <= 32'h00000000;
    end else begin
      if (ovf_msg_wr_s.valid) msg_cnt_s <= msg_cnt_s + 8'h01;
      if (ovf_msg_wr_ns.valid) begin
        msg_cnt_ns      <= msg_cnt_ns + 8'h01;
        last_payload_ns <= ovf_msg_wr_ns.payload;
      end
    end
  end
endmodule : movf_irq_sink

// File: bench/movf_irq_monitor.sv
// Concurrent checks on the ports of the monitor overflow interrupt block
`timescale 1ns/100ps
module movf_irq_monitor
  import movf_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [1023:0] ovf_event,
  input wire logic [1023:0] ovf_event_long,
  input wire logic          ctl_wr,
  input wire logic          msg_mode,
  input wire movf_msg_cfg_t msg_cfg_s,
  input wire logic          ovf_irq_line_s,
  input wire logic          ovf_irq_line_ns,
  input wire movf_msg_wr_t  ovf_msg_wr_s,
  input wire movf_msg_wr_t  ovf_msg_wr_ns,
  input wire logic [5:0]    overflow_summary_reg_s,
  input wire movf_mon_id_t  monitor_id_reg,
  input wire logic          cache_usage_has_ovf_bitmap,
  input wire logic          bandwidth_usage_has_ovf_bitmap
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ev_s  = (|ovf_event[511:0]) | (|ovf_event_long[511:0]);
  wire ev_ns = (|ovf_event[1023:512]) | (|ovf_event_long[1023:512]);
  a_wire_quiet_msg: assert property ($past(msg_mode) |->
    !ovf_irq_line_s && !ovf_irq_line_ns) else $error("wired line active in message mode");
  a_msg_s_cause: assert property (ovf_msg_wr_s.valid |-> $past(msg_mode) && $past(ev_s))
    else $error("secure message without overflow event");
  a_msg_ns_cause: assert property (ovf_msg_wr_ns.valid |->
    $past(msg_mode) && $past(ev_ns)) else $error("non-secure message without overflow event");
  a_msg_cfg_use: assert property (ovf_msg_wr_s.valid |->
    ovf_msg_wr_s.addr == {msg_cfg_s.addr_high, msg_cfg_s.addr_low} &&
    ovf_msg_wr_s.payload == msg_cfg_s.payload &&
    ovf_msg_wr_s.attributes == msg_cfg_s.attributes &&
    ovf_msg_wr_s.partition_info == msg_cfg_s.partition_info)
    else $error("secure message fields differ from config");
  a_line_rise_cause: assert property ($rose(ovf_irq_line_s) |->
    $past(ev_s) || $past(ctl_wr)) else $error("line rose without cause");
  a_line_fall_cause: assert property ($fell(ovf_irq_line_s) |->
    $past(ctl_wr) || $past(msg_mode)) else $error("line fell without a flag clear");
  a_id_after_reset: assert property ($past(rst_n) |-> monitor_id_reg == 3'h7 &&
    cache_usage_has_ovf_bitmap && bandwidth_usage_has_ovf_bitmap) else $error("identification bits low");
  a_summary_clear: assert property ($fell(|overflow_summary_reg_s[3:0]) |-> $past(ctl_wr))
    else $error("summary cleared without a write");
  c_msg_ns: cover property (ovf_msg_wr_ns.valid);
  c_line_s: cover property ($rose(ovf_irq_line_s));
  c_sum_clr: cover property ($fell(|overflow_summary_reg_s[3:0]));
endmodule : movf_irq_monitor
bind movf_irq movf_irq_monitor i_mon (.clk(clk), .rst_n(rst_n), .ovf_event(ovf_event),
  .ovf_event_long(ovf_event_long), .ctl_wr(ctl_wr), .msg_mode(msg_mode), .msg_cfg_s(msg_cfg_s),
  .ovf_irq_line_s(ovf_irq_line_s), .ovf_irq_line_ns(ovf_irq_line_ns), .ovf_msg_wr_s(ovf_msg_wr_s),
  .ovf_msg_wr_ns(ovf_msg_wr_ns), .overflow_summary_reg_s(overflow_summary_reg_s),
  .monitor_id_reg(monitor_id_reg), .cache_usage_has_ovf_bitmap(cache_usage_has_ovf_bitmap),
  .bandwidth_usage_has_ovf_bitmap(bandwidth_usage_has_ovf_bitmap));

// File: bench/testbench.sv
// Self-checking bench for the monitor overflow interrupt block
`timescale 1ns/100ps
module testbench;
  import movf_pkg::*;
  localparam movf_msg_cfg_t CFG_S  = {32'h00001000, 32'h0, 32'h1, 32'h000000A5, 32'h3};
  localparam movf_msg_cfg_t CFG_NS = {32'h00002000, 32'h0, 32'h1, 32'h0000005A, 32'h4};
  logic clk = 1'b0, rst_n = 1'b0, ctl_wr = 1'b0;
  logic ctl_space = 1'b0, ctl_type = 1'b0, msg_mode = 1'b0;
  logic [1023:0] ev = '0, ev_long = '0;
  logic [1:0] ctl_ris = 2'h0, ris_s = 2'h0, ris_ns = 2'h0;
  logic [5:0] ctl_mon = 6'h00, sum_s, sum_ns;
  logic [2:0] ctl_val = 3'h0;
  logic [15:0] idx_s = 16'h0000, idx_ns = 16'h0000;
  logic line_s, line_ns, has_c, has_b;
  logic [31:0] csu_s, mbw_s, pay_ns, csu_ns, mbw_ns;
  logic [7:0] cnt_s, cnt_ns;
  movf_msg_wr_t wr_s, wr_ns;
  movf_mon_id_t id;
  int num_errors = 0, checks_done = 0, cycles = 0;
  movf_irq i_dut (.clk(clk), .rst_n(rst_n), .ovf_event(ev), .ovf_event_long(ev_long),
    .ctl_wr(ctl_wr), .ctl_space(ctl_space), .ctl_type(ctl_type), .ctl_ris(ctl_ris),
    .ctl_mon(ctl_mon), .ctl_ovf_flag(ctl_val[2]), .ctl_ovf_flag_long(ctl_val[1]),
    .ctl_ovf_irq_enable(ctl_val[0]), .resource_instance_select_s(ris_s),
    .monitor_instance_index_s(idx_s), .resource_instance_select_ns(ris_ns),
    .monitor_instance_index_ns(idx_ns), .msg_cfg_s(CFG_S), .msg_cfg_ns(CFG_NS),
    .msg_mode(msg_mode), .ovf_irq_line_s(line_s), .ovf_irq_line_ns(line_ns),
    .ovf_msg_wr_s(wr_s), .ovf_msg_wr_ns(wr_ns), .overflow_summary_reg_s(sum_s),
    .overflow_summary_reg_ns(sum_ns), .cache_usage_ovf_bitmap_s(csu_s),
    .bandwidth_usage_ovf_bitmap_s(mbw_s), .cache_usage_ovf_bitmap_ns(csu_ns),
    .bandwidth_usage_ovf_bitmap_ns(mbw_ns), .monitor_id_reg(id),
    .cache_usage_has_ovf_bitmap(has_c), .bandwidth_usage_has_ovf_bitmap(has_b));
  movf_irq_sink i_sink (.clk(clk), .rst_n(rst_n), .ovf_msg_wr_s(wr_s), .ovf_msg_wr_ns(wr_ns),
    .msg_cnt_s(cnt_s), .msg_cnt_ns(cnt_ns), .last_payload_ns(pay_ns));
  always #4 clk = ~clk;
  // Hang guard: the whole run needs well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Event index is ((space*2+type)*4+ris)*64+mon; outputs settle by the closing edge
  task pulse(input int i, input logic lng);
    @(negedge clk);
    if (lng) ev_long[i] = 1'b1;
    else ev[i] = 1'b1;
    @(negedge clk);
    ev = '0;
    ev_long = '0;
  endtask : pulse
  // Control value is {flag, long flag, enable}
  task wr_ctl(input logic sp, input logic ty, input logic [1:0] r, input logic [5:0] m,
              input logic [2:0] v);
    @(negedge clk);
    {ctl_space, ctl_type, ctl_ris, ctl_mon, ctl_val, ctl_wr} = {sp, ty, r, m, v, 1'b1};
    @(negedge clk);
    ctl_wr = 1'b0;
  endtask : wr_ctl
  task t_wired();
    {ris_s, idx_s} = {2'h1, 16'h0013};
    wr_ctl(1'b0, 1'b0, 2'h1, 6'd5, 3'h1);
    wr_ctl(1'b0, 1'b0, 2'h1, 6'd6, 3'h1);
    pulse(69, 1'b0);
    chk(line_s, 1'b1);
    chk(line_ns, 1'b0);
    chk(sum_s, 6'h12);
    pulse(70, 1'b0);
    chk(csu_s, 32'h60);
    wr_ctl(1'b0, 1'b0, 2'h1, 6'd5, 3'h1);
    chk(line_s, 1'b1);
    wr_ctl(1'b0, 1'b0, 2'h1, 6'd6, 3'h1);
    chk(line_s, 1'b0);
    chk(sum_s, 6'h00);
    // Non-secure bandwidth monitor 3 of resource instance 0 is index 771
    wr_ctl(1'b1, 1'b1, 2'h0, 6'd3, 3'h1);
    pulse(771, 1'b0);
    chk(line_ns, 1'b1);
    chk(line_s, 1'b0);
    chk(sum_ns, 6'h21);
    chk(mbw_ns, 32'h8);
    wr_ctl(1'b1, 1'b1, 2'h0, 6'd3, 3'h1);
    chk(line_ns, 1'b0);
    chk(sum_ns, 6'h00);
  endtask : t_wired
  task t_long_high();
    idx_s = 16'h0027;
    pulse(360, 1'b1);
    chk(mbw_s, 32'h100);
    chk(sum_s, 6'h22);
    chk(line_s, 1'b0);
    wr_ctl(1'b0, 1'b1, 2'h1, 6'd40, 3'h0);
    chk(sum_s, 6'h00);
  endtask : t_long_high
  task t_msg();
    msg_mode = 1'b1;
    idx_ns = 16'h001F;
    wr_ctl(1'b1, 1'b0, 2'h0, 6'd0, 3'h1);
    wr_ctl(1'b0, 1'b0, 2'h0, 6'd0, 3'h1);
    pulse(512, 1'b0);
    pulse(512, 1'b0);
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    @(negedge clk);
    chk(cnt_ns, 8'h01);
    chk(cnt_s, 8'h01);
    chk(pay_ns, 32'h5A);
    chk(line_ns, 1'b0);
    chk(sum_ns, 6'h11);
    chk(csu_ns, 32'h1);
    chk(sum_s, 6'h01);
    ris_ns = 2'h1;
    @(negedge clk);
    chk(sum_ns, 6'h01);
    chk(csu_ns, 32'h0);
  endtask : t_msg
  task wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    @(negedge clk);
    chk({29'h0, id}, 32'h7);
    chk({has_c, has_b}, 2'h3);
    t_wired();
    t_long_high();
    t_msg();
    wrap_up();
  end
endmodule : testbench
